// ### rrs_pkg.sv
package rrs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned TEL_RUN_HZ    = 25;
  localparam int unsigned TEL_STBY_HZ   = 1;
  localparam int unsigned PG_DLY_MIN_US = 200;
  localparam int unsigned PG_DLY_MAX_US = 25000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int unsigned PG_SEL_STEPS  = 15;

  localparam logic [31:0] TEL_RUN_CYC     = 32'(CLK_HZ / TEL_RUN_HZ);
  localparam logic [31:0] TEL_STBY_CYC    = 32'(CLK_HZ / TEL_STBY_HZ);
  localparam logic [31:0] PG_DLY_MIN_CYC  = 32'(PG_DLY_MIN_US * CYC_PER_US);
  localparam logic [31:0] PG_DLY_MAX_CYC  = 32'(PG_DLY_MAX_US * CYC_PER_US);
  localparam logic [31:0] PG_DLY_STEP_CYC = 32'((PG_DLY_MAX_CYC - PG_DLY_MIN_CYC) / PG_SEL_STEPS);
  localparam logic [4:0]  PG_BLANK_SW     = 5'h10;
  localparam logic [15:0] SW_HALF_CYC     = 16'h0032;

  ////////////////////////////////////////////////////////////////////////////////
  // thermal thresholds, 1 degree per bit
  localparam logic signed [15:0] TEMP_WARN_C = 16'sh0096;
  localparam logic signed [15:0] TEMP_SHDN_C = 16'sh00AA;
  localparam logic signed [15:0] TEMP_HYST_C = 16'sh0014;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_ON_OFF       = 8'h01;
  localparam logic [7:0] IDX_FAULT_STATUS = 8'h79;
  localparam logic [7:0] IDX_VIN_VAL      = 8'h88;
  localparam logic [7:0] IDX_IIN_VAL      = 8'h89;
  localparam logic [7:0] IDX_VOUT_VAL     = 8'h8B;
  localparam logic [7:0] IDX_IOUT_VAL     = 8'h8C;
  localparam logic [7:0] IDX_TEMP_VAL     = 8'h8D;
  localparam logic [7:0] IDX_MARGIN_UP    = 8'hE5;
  localparam logic [7:0] IDX_OFFSET_CMD   = 8'hE8;
  localparam logic [7:0] IDX_MARGIN_DOWN  = 8'hED;

  // on/off byte fields
  localparam int unsigned OP_ON_BIT  = 7;
  localparam int unsigned OP_SEL_LSB = 4;
  localparam logic [1:0]  OP_SEL_LO  = 2'h1;
  localparam logic [1:0]  OP_SEL_HI  = 2'h2;
  localparam logic [7:0]  OP_RST     = 8'h80;
  localparam logic [15:0] MARGIN_RST = 16'h0000;

  // fault status fields
  localparam int unsigned STS_CML  = 1;
  localparam int unsigned STS_TEMP = 2;
  localparam int unsigned STS_PGN  = 11;
  localparam int unsigned STS_VOUT = 15;
  localparam logic [15:0] STS_RST  = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // telemetry channels
  localparam logic [2:0] CH_VIN  = 3'h0;
  localparam logic [2:0] CH_IIN  = 3'h1;
  localparam logic [2:0] CH_VOUT = 3'h2;
  localparam logic [2:0] CH_IOUT = 3'h3;
  localparam logic [2:0] CH_TEMP = 3'h4;
  localparam int unsigned N_CH   = 5;
  localparam logic [4:0] MASK_ALL  = 5'h1F;
  localparam logic [4:0] MASK_STBY = 5'h15;
  localparam logic [4:0] MASK_TEMP = 5'h10;

  typedef enum logic [1:0] {
    ST_MSHDN,
    ST_THSHDN,
    ST_STBY,
    ST_RUN
  } rrs_state_e;

  typedef struct packed {
    logic        valid;
    logic [2:0]  chan;
    logic [15:0] data;
  } rrs_adc_s;

endpackage

// ### rrs_sync.sv
module rrs_sync #(
  parameter int WIDTH = 1
) (
  input  logic             clk,
  input  logic             rst,
  input  logic             ce,
  input  logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ### rrs_top.sv
// Function
// - three shutdown controls: master pin, standby pin, on bit
// - master pin low: master shutdown, no regulation, bus silent
// - master shutdown returns every host register to reset value
// - standby pin low or on bit clear: stop regulating, bus alive
// - standby telemetry at 1Hz, only input, output voltage and temperature
// - rising on bit clears latched faults and releases alert unless a temperature warning is still live
// - standby keeps host registers, margin target resumes
// - regulate only with both pins high and on bit set
// - on bit set at power-on and master shutdown entry
// - master pin low overrides standby pin and on bit
// - track input below reference selects track target
// - discontinuous mode while tracking during start-up
// - power good low out of window, default window flag
// - power good rise delayed by selectable interval up to 25ms
// - power good fall blanked for 16 switching cycles
// - over or undervoltage forces continuous mode except while tracking
// - above 150C set temperature status and assert alert
// - above 170C stop regulating, bus silent, temperature still converted
// - both thermal levels clear 20C below their trip
// - temperature status latched until host clears it
// - sense return tied high: amplifiers high impedance
// - clock out is internal switching clock inverted
// - standby line shared, pulled low on own fault
// - latched status bits cleared where host writes one, all of them on a rising on bit or in master shutdown; power-good bit reads live
// - on bit lives in byte register at index 0x01
module rrs_top #(
  parameter logic [31:0] TEL_RUN_CYC     = rrs_pkg::TEL_RUN_CYC,
  parameter logic [31:0] TEL_STBY_CYC    = rrs_pkg::TEL_STBY_CYC,
  parameter logic [31:0] PG_DLY_MIN_CYC  = rrs_pkg::PG_DLY_MIN_CYC,
  parameter logic [31:0] PG_DLY_STEP_CYC = rrs_pkg::PG_DLY_STEP_CYC,
  parameter logic [15:0] SW_HALF_CYC     = rrs_pkg::SW_HALF_CYC
) (
  input  logic              clk,
  input  logic              rst,
  input  logic              ce,
  input  logic [9:0]        avs_address,
  input  logic              avs_read,
  input  logic              avs_write,
  input  logic [31:0]       avs_writedata,
  input  logic [3:0]        avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  input  logic              master_run_pin,
  input  logic              standby_run_pin_in,
  output logic              standby_run_pin_out,
  output logic              standby_run_pin_oe,
  input  logic              vout_ov_cmp,
  input  logic              vout_uv_cmp,
  input  logic              track_below_ref,
  input  logic              window_limit_pin,
  input  logic              sense_return_tied,
  input  logic [3:0]        good_delay_select_pin,
  input  rrs_pkg::rrs_adc_s adc,
  output logic              adc_start,
  output logic [4:0]        adc_chan_mask,
  output logic              regulate,
  output logic              track_target_sel,
  output logic              dcm_mode,
  output logic              ccm_force,
  output logic              window_default,
  output logic              amp_hiz,
  output logic [15:0]       margin_target,
  output logic              output_ok_flag,
  output logic              output_ok_flag_oe,
  output logic              alert_n,
  output logic              phase_shifted_clock_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic [10:0] sync_in;
  logic [10:0] sync_out;
  logic        mrun_s;
  logic        srun_s;
  logic        ov_s;
  logic        uv_s;
  logic        trk_s;
  logic        wlim_s;
  logic        vss_s;
  logic [3:0]  dsel_s;

  assign sync_in = {master_run_pin, standby_run_pin_in, vout_ov_cmp, vout_uv_cmp,
                    track_below_ref, window_limit_pin, sense_return_tied,
                    good_delay_select_pin};

  rrs_sync #(.WIDTH(11)) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (sync_in),
    .q   (sync_out)
  );

  assign {mrun_s, srun_s, ov_s, uv_s, trk_s, wlim_s, vss_s, dsel_s} = sync_out;

  ////////////////////////////////////////////////////////////////////////////////
  // run state

  rrs_pkg::rrs_state_e state_q;
  rrs_pkg::rrs_state_e state_d;
  logic [7:0]          op_q;
  logic                thot_q;
  logic                warn_q;

  always_comb begin
    if (!mrun_s) begin
      state_d = rrs_pkg::ST_MSHDN;
    end else if (thot_q) begin
      state_d = rrs_pkg::ST_THSHDN;
    end else if (!srun_s || !op_q[rrs_pkg::OP_ON_BIT]) begin
      state_d = rrs_pkg::ST_STBY;
    end else begin
      state_d = rrs_pkg::ST_RUN;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= rrs_pkg::ST_MSHDN;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // avalon slave, one wait cycle per access

  logic [7:0]  idx;
  logic        alive;
  logic        wr_take;
  logic        rd_take;
  logic        mapped;
  logic        wr_ok;
  logic [31:0] rd_mux;
  logic [15:0] be_mask;
  logic [15:0] vcmd_q;
  logic [15:0] mhi_q;
  logic [15:0] mlo_q;
  logic [15:0] status_q;
  logic [15:0] tel_q [rrs_pkg::N_CH];
  logic        pg_q;

  assign idx     = avs_address[9:2];
  assign alive   = (state_q == rrs_pkg::ST_RUN) || (state_q == rrs_pkg::ST_STBY);
  assign wr_take = avs_write && !avs_waitrequest;
  assign rd_take = avs_read && !avs_waitrequest;
  assign be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    wr_ok  = 1'b1;
    if (idx == rrs_pkg::IDX_ON_OFF) begin
      rd_mux = {24'h00_0000, op_q};
    end else if (idx == rrs_pkg::IDX_FAULT_STATUS) begin
      rd_mux = {16'h0000, status_q | (16'(!pg_q) << rrs_pkg::STS_PGN)};
    end else if (idx == rrs_pkg::IDX_OFFSET_CMD) begin
      rd_mux = {16'h0000, vcmd_q};
    end else if (idx == rrs_pkg::IDX_MARGIN_UP) begin
      rd_mux = {16'h0000, mhi_q};
    end else if (idx == rrs_pkg::IDX_MARGIN_DOWN) begin
      rd_mux = {16'h0000, mlo_q};
    end else if (idx == rrs_pkg::IDX_VIN_VAL) begin
      rd_mux = {16'h0000, tel_q[rrs_pkg::CH_VIN]};
      wr_ok  = 1'b0;
    end else if (idx == rrs_pkg::IDX_IIN_VAL) begin
      rd_mux = {16'h0000, tel_q[rrs_pkg::CH_IIN]};
      wr_ok  = 1'b0;
    end else if (idx == rrs_pkg::IDX_VOUT_VAL) begin
      rd_mux = {16'h0000, tel_q[rrs_pkg::CH_VOUT]};
      wr_ok  = 1'b0;
    end else if (idx == rrs_pkg::IDX_IOUT_VAL) begin
      rd_mux = {16'h0000, tel_q[rrs_pkg::CH_IOUT]};
      wr_ok  = 1'b0;
    end else if (idx == rrs_pkg::IDX_TEMP_VAL) begin
      rd_mux = {16'h0000, tel_q[rrs_pkg::CH_TEMP]};
      wr_ok  = 1'b0;
    end else begin
      mapped = 1'b0;
      wr_ok  = 1'b0;
    end
  end

  // silent states keep waitrequest high; the master hangs until its timeout
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (ce) begin
      if (!avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
      end else if ((avs_read || avs_write) && alive) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // host registers

  logic on_rise;

  assign on_rise = wr_take && (idx == rrs_pkg::IDX_ON_OFF) && avs_byteenable[0] &&
                   avs_writedata[rrs_pkg::OP_ON_BIT] && !op_q[rrs_pkg::OP_ON_BIT];

  // standby leaves these untouched, so the margin target comes back as it was
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_q   <= rrs_pkg::OP_RST;
      vcmd_q <= rrs_pkg::MARGIN_RST;
      mhi_q  <= rrs_pkg::MARGIN_RST;
      mlo_q  <= rrs_pkg::MARGIN_RST;
    end else if (ce) begin
      if (!mrun_s) begin
        op_q   <= rrs_pkg::OP_RST;
        vcmd_q <= rrs_pkg::MARGIN_RST;
        mhi_q  <= rrs_pkg::MARGIN_RST;
        mlo_q  <= rrs_pkg::MARGIN_RST;
      end else if (wr_take) begin
        if (idx == rrs_pkg::IDX_ON_OFF && avs_byteenable[0]) begin
          op_q <= avs_writedata[7:0];
        end
        if (idx == rrs_pkg::IDX_OFFSET_CMD) begin
          vcmd_q <= (vcmd_q & ~be_mask) | (avs_writedata[15:0] & be_mask);
        end
        if (idx == rrs_pkg::IDX_MARGIN_UP) begin
          mhi_q <= (mhi_q & ~be_mask) | (avs_writedata[15:0] & be_mask);
        end
        if (idx == rrs_pkg::IDX_MARGIN_DOWN) begin
          mlo_q <= (mlo_q & ~be_mask) | (avs_writedata[15:0] & be_mask);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fault status and alert

  logic [15:0] sts_set;
  logic [15:0] sts_clr;
  logic [15:0] status_d;
  logic        pg_fall;

  always_comb begin
    sts_set                    = 16'h0000;
    sts_set[rrs_pkg::STS_TEMP] = warn_q;
    sts_set[rrs_pkg::STS_CML]  = (wr_take && !wr_ok) || (rd_take && !mapped);
    sts_set[rrs_pkg::STS_VOUT] = pg_fall;
    sts_clr = 16'h0000;
    if (wr_take && idx == rrs_pkg::IDX_FAULT_STATUS) begin
      sts_clr = avs_writedata[15:0] & be_mask;
    end
    if (on_rise) begin
      sts_clr = 16'hFFFF;
    end
    // set wins over clear, a live warning cannot be wiped
    status_d = (status_q & ~sts_clr) | sts_set;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= rrs_pkg::STS_RST;
      alert_n  <= 1'b1;
    end else if (ce) begin
      status_q <= mrun_s ? status_d : rrs_pkg::STS_RST;
      alert_n  <= !(mrun_s && (|status_d));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // switching clock and phase-shifted copy

  logic [15:0] sw_cnt_q;
  logic        sw_phase_q;
  logic        sw_half;
  logic        sw_tick;

  assign sw_half = (sw_cnt_q == SW_HALF_CYC - 16'h0001);
  assign sw_tick = sw_half && !sw_phase_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_cnt_q                <= 16'h0000;
      sw_phase_q              <= 1'b0;
      phase_shifted_clock_out <= 1'b1;
    end else if (ce) begin
      if (!mrun_s) begin
        sw_cnt_q                <= 16'h0000;
        sw_phase_q              <= 1'b0;
        phase_shifted_clock_out <= 1'b1;
      end else if (sw_half) begin
        sw_cnt_q                <= 16'h0000;
        sw_phase_q              <= !sw_phase_q;
        phase_shifted_clock_out <= sw_phase_q;
      end else begin
        sw_cnt_q <= sw_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power good qualification

  logic        in_win;
  logic [31:0] dly_tgt;
  logic [31:0] dly_cnt_q;
  logic [4:0]  blank_q;
  logic        pg_d;

  assign in_win  = !ov_s && !uv_s;
  assign dly_tgt = PG_DLY_MIN_CYC + 32'(PG_DLY_STEP_CYC * {28'h000_0000, dsel_s});
  assign pg_fall = pg_q && regulate && !in_win && sw_tick &&
                   (blank_q == rrs_pkg::PG_BLANK_SW - 5'h01);

  always_comb begin
    pg_d = pg_q;
    if (!regulate || pg_fall) begin
      pg_d = 1'b0;
    end else if (in_win && !pg_q && dly_cnt_q >= dly_tgt) begin
      pg_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pg_q              <= 1'b0;
      dly_cnt_q         <= 32'h0000_0000;
      blank_q           <= 5'h00;
      output_ok_flag    <= 1'b0;
      output_ok_flag_oe <= 1'b1;
    end else if (ce) begin
      pg_q              <= pg_d;
      output_ok_flag    <= pg_d;
      output_ok_flag_oe <= !pg_d;
      if (!regulate || !in_win) begin
        dly_cnt_q <= 32'h0000_0000;
      end else if (!pg_q) begin
        dly_cnt_q <= dly_cnt_q + 32'h0000_0001;
      end
      if (!regulate || in_win || pg_fall) begin
        blank_q <= 5'h00;
      end else if (pg_q && sw_tick) begin
        blank_q <= blank_q + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // telemetry scheduling and capture

  logic [31:0]        tel_cnt_q;
  logic [31:0]        tel_per;
  logic [4:0]         tel_mask;
  logic [7:0]         keep8;
  logic signed [15:0] temp;

  assign tel_per = (state_q == rrs_pkg::ST_RUN) ? TEL_RUN_CYC : TEL_STBY_CYC;
  assign keep8   = {3'h0, adc_chan_mask};
  assign temp    = $signed(tel_q[rrs_pkg::CH_TEMP]);

  // thermal shutdown still converts temperature, otherwise it could never clear
  always_comb begin
    case (state_q)
      rrs_pkg::ST_RUN:    tel_mask = rrs_pkg::MASK_ALL;
      rrs_pkg::ST_STBY:   tel_mask = rrs_pkg::MASK_STBY;
      rrs_pkg::ST_THSHDN: tel_mask = rrs_pkg::MASK_TEMP;
      default:            tel_mask = 5'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tel_cnt_q     <= 32'h0000_0000;
      adc_start     <= 1'b0;
      adc_chan_mask <= 5'h00;
    end else if (ce) begin
      adc_start <= 1'b0;
      if (state_q == rrs_pkg::ST_MSHDN) begin
        tel_cnt_q     <= 32'h0000_0000;
        adc_chan_mask <= 5'h00;
      end else if (tel_cnt_q >= tel_per - 32'h0000_0001) begin
        tel_cnt_q     <= 32'h0000_0000;
        adc_start     <= 1'b1;
        adc_chan_mask <= tel_mask;
      end else begin
        tel_cnt_q <= tel_cnt_q + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < rrs_pkg::N_CH; i++) begin
        tel_q[i] <= 16'h0000;
      end
    end else if (ce) begin
      if (adc.valid && keep8[adc.chan]) begin
        tel_q[adc.chan] <= adc.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // thermal levels with hysteresis

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warn_q <= 1'b0;
      thot_q <= 1'b0;
    end else if (ce) begin
      if (temp > rrs_pkg::TEMP_WARN_C) begin
        warn_q <= 1'b1;
      end else if (temp <= rrs_pkg::TEMP_WARN_C - rrs_pkg::TEMP_HYST_C) begin
        warn_q <= 1'b0;
      end
      if (temp > rrs_pkg::TEMP_SHDN_C) begin
        thot_q <= 1'b1;
      end else if (temp <= rrs_pkg::TEMP_SHDN_C - rrs_pkg::TEMP_HYST_C) begin
        thot_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // converter control outputs

  logic [1:0] msel;
  logic       run_d;

  assign msel  = op_q[rrs_pkg::OP_SEL_LSB +: 2];
  assign run_d = (state_d == rrs_pkg::ST_RUN);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regulate            <= 1'b0;
      track_target_sel    <= 1'b0;
      dcm_mode            <= 1'b0;
      ccm_force           <= 1'b0;
      window_default      <= 1'b0;
      amp_hiz             <= 1'b0;
      margin_target       <= rrs_pkg::MARGIN_RST;
      standby_run_pin_out <= 1'b0;
      standby_run_pin_oe  <= 1'b0;
    end else if (ce) begin
      regulate            <= run_d;
      track_target_sel    <= run_d && trk_s;
      dcm_mode            <= run_d && trk_s;
      ccm_force           <= run_d && !trk_s && (ov_s || uv_s);
      window_default      <= wlim_s;
      amp_hiz             <= vss_s;
      margin_target       <= (msel == rrs_pkg::OP_SEL_HI) ? mhi_q :
                             (msel == rrs_pkg::OP_SEL_LO) ? mlo_q : vcmd_q;
      standby_run_pin_out <= 1'b0;
      standby_run_pin_oe  <= (state_d == rrs_pkg::ST_THSHDN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence hot_seq;
    temp > rrs_pkg::TEMP_WARN_C;
  endsequence

  sequence silent_seq;
    (state_q == rrs_pkg::ST_MSHDN || state_q == rrs_pkg::ST_THSHDN) [*2];
  endsequence

  mshdn_enter_a: assert property (!mrun_s |=> state_q == rrs_pkg::ST_MSHDN && !regulate)
    else $error("master pin low did not force shutdown");
  mshdn_regs_a: assert property (!mrun_s |=> op_q == rrs_pkg::OP_RST && vcmd_q == 16'h0000)
    else $error("registers not restored in master shutdown");
  stby_stop_a: assert property (!(srun_s && op_q[rrs_pkg::OP_ON_BIT]) |=> !regulate)
    else $error("regulating while in standby");
  bus_silent_a: assert property (silent_seq |-> avs_waitrequest)
    else $error("bus answered while shut down");
  temp_warn_a: assert property (hot_seq ##1 mrun_s |=>
                                status_q[rrs_pkg::STS_TEMP] && !alert_n)
    else $error("temperature warning not raised");
  hyst_hold_a: assert property (warn_q && temp > 16'sh0082 |=> warn_q)
    else $error("warning cleared inside hysteresis");
  w1c_only_a: assert property ($fell(status_q[rrs_pkg::STS_TEMP]) |->
                               $past(sts_clr[rrs_pkg::STS_TEMP]) || !$past(mrun_s))
    else $error("status bit cleared without request");
  on_clear_a: assert property (on_rise && mrun_s |=> (status_q & ~$past(sts_set)) == 16'h0000)
    else $error("faults not cleared by on bit rise");
  stby_tel_a: assert property (adc_start && state_q == rrs_pkg::ST_STBY
                               && $past(state_q) == rrs_pkg::ST_STBY |->
                               adc_chan_mask == rrs_pkg::MASK_STBY)
    else $error("wrong channels refreshed in standby");
  pg_blank_a: assert property ($fell(pg_q) && $past(regulate) && regulate |->
                               $past(blank_q) == 5'h0F && $past(sw_tick))
    else $error("power good fell before blanking");
  pg_delay_a: assert property ($rose(pg_q) |-> $past(dly_cnt_q) >= $past(dly_tgt))
    else $error("power good rose before delay");
  clk_anti_a: assert property (mrun_s && $past(mrun_s) |-> phase_shifted_clock_out != sw_phase_q)
    else $error("clock out not in antiphase");

endmodule

// ### rrs_companion.sv
module rrs_companion (
  input  wire logic standby_run_pin_out,
  input  wire logic standby_run_pin_oe,
  input  wire logic own_fault,
  output wire logic standby_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up keeps the shared line high unless either phase pulls it
  assign standby_wire = !((standby_run_pin_oe && !standby_run_pin_out) || own_fault);
endmodule

// ### rrs_top_tb.sv
module rrs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 0, rst = 1, mrun = 0, flt = 0, rd = 0, wr = 0, stby;
  logic [9:0]        adr = '0;
  logic [31:0]       wd = '0, rdat, d;
  logic              wreq, sb_o, sb_oe, start, reg_on, tsel, dcm, ccm, wdef, hiz, ck, c0;
  logic              ok, okoe, al, ce = 1, ov = 0, uv = 0, trk = 0, wlim = 1, vss = 0;
  logic [3:0]        be = 4'hF, dsel = 4'h0;
  logic [4:0]        mask;
  logic [15:0]       mt;
  int                failures = 0, n_checks = 0, cyc = 0;
  rrs_pkg::rrs_adc_s adc = '0;
  always #2.5 clk = ~clk;
  rrs_top #(.TEL_RUN_CYC(32'h000000C8), .TEL_STBY_CYC(32'h000003E8),
    .PG_DLY_MIN_CYC(32'h0000000A), .PG_DLY_STEP_CYC(32'h00000004),
    .SW_HALF_CYC(16'h0004)) rrs_top_i (.clk(clk), .rst(rst), .ce(ce),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .master_run_pin(mrun), .standby_run_pin_in(stby), .standby_run_pin_out(sb_o),
    .standby_run_pin_oe(sb_oe), .vout_ov_cmp(ov), .vout_uv_cmp(uv),
    .track_below_ref(trk), .window_limit_pin(wlim), .sense_return_tied(vss),
    .good_delay_select_pin(dsel), .adc(adc), .adc_start(start), .adc_chan_mask(mask),
    .regulate(reg_on), .track_target_sel(tsel), .dcm_mode(dcm), .ccm_force(ccm),
    .window_default(wdef), .amp_hiz(hiz), .margin_target(mt), .output_ok_flag(ok),
    .output_ok_flag_oe(okoe), .alert_n(al), .phase_shifted_clock_out(ck));
  rrs_companion rrs_companion_i (.standby_run_pin_out(sb_o), .standby_run_pin_oe(sb_oe),
    .own_fault(flt), .standby_wire(stby));
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // request held until waitrequest seen low, then dropped
  task acc(input logic w, input logic [7:0] i, input logic [15:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= {i, 2'h0};
    wd <= {16'h0000, v};
    do @(posedge clk); while (wreq !== 1'b0);
    d = rdat;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task wait_start;
    do @(negedge clk); while (start !== 1'b1);
  endtask
  task temp_set(input logic [15:0] v);
    @(posedge clk);
    adc <= '{1'b1, rrs_pkg::CH_TEMP, v};
    @(posedge clk);
    adc <= '0;
  endtask
  task settle;
    repeat (8) @(posedge clk);
  endtask
  // limit sized at twenty slow telemetry periods
  always @(posedge clk) if (++cyc == 20000) begin
    failures++;
    close_out;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    mrun <= 1'b1;
    acc(1'b0, rrs_pkg::IDX_ON_OFF, 16'h0000); chk(d, 32'h00000080);
    acc(1'b1, rrs_pkg::IDX_MARGIN_UP, 16'h1234);
    acc(1'b1, rrs_pkg::IDX_ON_OFF, 16'h0020);
    settle; chk(reg_on, 32'h0);
    wait_start; chk(mask, rrs_pkg::MASK_STBY);
    acc(1'b0, rrs_pkg::IDX_MARGIN_UP, 16'h0000); chk(d, 32'h00001234);
    acc(1'b1, rrs_pkg::IDX_ON_OFF, 16'h00A0);
    settle; chk(reg_on, 32'h1);
    chk(mt, 32'h00001234);
    wait_start; chk(mask, rrs_pkg::MASK_ALL);
    be <= 4'h1;
    acc(1'b1, rrs_pkg::IDX_MARGIN_UP, 16'hFFFF);
    be <= 4'hF;
    acc(1'b0, rrs_pkg::IDX_MARGIN_UP, 16'h0000); chk(d, 32'h000012FF);
    $display("test standby done");
    acc(1'b0, 8'h02, 16'h0000); chk(d, 32'h0);
    acc(1'b1, rrs_pkg::IDX_FAULT_STATUS, 16'h0000);
    acc(1'b0, rrs_pkg::IDX_FAULT_STATUS, 16'h0000); chk(d[1], 32'h1);
    chk(al, 32'h0);
    acc(1'b1, rrs_pkg::IDX_FAULT_STATUS, 16'h0002);
    acc(1'b0, rrs_pkg::IDX_FAULT_STATUS, 16'h0000); chk(d[1], 32'h0);
    chk(al, 32'h1);
    $display("test status done");
    chk(wdef, 32'h1);
    wlim <= 1'b0;
    vss <= 1'b1;
    dsel <= 4'h3;
    trk <= 1'b1;
    ov <= 1'b1;
    settle; chk(wdef, 32'h0);
    chk(hiz, 32'h1);
    chk(tsel, 32'h1);
    chk(dcm, 32'h1);
    chk(ccm, 32'h0);
    trk <= 1'b0;
    settle; chk(ccm, 32'h1);
    chk(tsel, 32'h0);
    ov <= 1'b0;
    settle;
    uv <= 1'b1;
    repeat (112) @(posedge clk); chk(ok, 32'h1);
    repeat (24) @(posedge clk); chk(ok, 32'h0);
    chk(okoe, 32'h1);
    uv <= 1'b0;
    repeat (18) @(posedge clk); chk(ok, 32'h0);
    repeat (12) @(posedge clk); chk(ok, 32'h1);
    c0 = ck;
    repeat (4) @(posedge clk); chk(ck, !c0);
    acc(1'b1, rrs_pkg::IDX_FAULT_STATUS, 16'hFFFF);
    settle; chk(al, 32'h1);
    temp_set(16'h00A0);
    settle; chk(al, 32'h0);
    temp_set(16'h007D);
    acc(1'b0, rrs_pkg::IDX_FAULT_STATUS, 16'h0000); chk(d[2], 32'h1);
    acc(1'b1, rrs_pkg::IDX_FAULT_STATUS, 16'h0004);
    acc(1'b0, rrs_pkg::IDX_FAULT_STATUS, 16'h0000); chk(d[2], 32'h0);
    temp_set(16'h00B4);
    settle; chk(reg_on, 32'h0);
    chk(sb_oe, 32'h1);
    chk(stby, 32'h0);
    temp_set(16'h00A0);
    settle; chk(reg_on, 32'h0);
    temp_set(16'h0082);
    settle; chk(reg_on, 32'h1);
    $display("test analog done");
    flt <= 1'b1;
    settle; chk(reg_on, 32'h0);
    flt <= 1'b0;
    settle; chk(reg_on, 32'h1);
    ce <= 1'b0;
    mrun <= 1'b0;
    settle; chk(reg_on, 32'h1);
    ce <= 1'b1;
    settle; chk(reg_on, 32'h0);
    chk(ck, 32'h1);
    mrun <= 1'b1;
    settle;
    acc(1'b0, rrs_pkg::IDX_ON_OFF, 16'h0000); chk(d, 32'h00000080);
    acc(1'b0, rrs_pkg::IDX_MARGIN_UP, 16'h0000); chk(d, 32'h0);
    $display("test shutdown done");
    close_out;
  end
endmodule
